// >>> shared/adcseq_pkg.sv
// Package for the arbitrary-channel converter sequencer
package adcseq_pkg;

    // Register byte offsets
    localparam logic [7:0] OFS_COMMON_RESULT = 8'h00;
    localparam logic [7:0] OFS_CONFIG        = 8'h04;
    localparam logic [7:0] OFS_CONTROL       = 8'h08;
    localparam logic [7:0] OFS_COMPARE       = 8'h10;
    localparam logic [7:0] OFS_STATUS        = 8'h14;
    localparam logic [7:0] OFS_CHAN_FIRST    = 8'h18;
    localparam logic [7:0] OFS_CHAN_LAST     = 8'h38;
    localparam logic [7:0] OFS_SLOT_LO       = 8'h5C;
    localparam logic [7:0] OFS_SLOT_HI       = 8'h60;
    localparam logic [7:0] OFS_ANY_CFG       = 8'h64;

    // Config register fields
    localparam int CFG_POWER_BIT   = 0;
    localparam int CFG_WIN_BIT     = 1;
    localparam int CFG_PREH_LSB    = 4;
    localparam int CFG_RES_LSB     = 7;
    localparam int CFG_PREL_BIT    = 14;
    // Control register fields
    localparam int CTL_IRQ_EN_BIT  = 1;
    localparam int CTL_WIN_IE_BIT  = 2;
    localparam int CTL_TRG_EN_BIT  = 3;
    localparam int CTL_TRGSEL_LSB  = 4;
    localparam int CTL_RUN_BIT     = 8;
    localparam int CTL_MODE_LSB    = 9;
    localparam int CTL_ALIGN_BIT   = 11;
    localparam int CTL_CMPCH_LSB   = 12;
    localparam int CTL_SHIFT_LSB   = 19;
    localparam int CTL_EDGE_LSB    = 24;
    // Status fields
    localparam int STA_EOC_BIT     = 0;
    localparam int STA_WIN_BIT     = 1;
    localparam int STA_BUSY_BIT    = 2;
    localparam int STA_POWER_BIT   = 3;
    // Any-channel config fields
    localparam int ANY_MDEN_BIT    = 0;
    localparam int ANY_NUM_LSB     = 4;
    // Common result fields
    localparam int RES_VALID_BIT   = 21;
    localparam int RES_OVR_BIT     = 20;
    localparam int RES_CH_LSB      = 16;

    localparam logic [31:0] RESET_WORD = 32'h0000_0000;

    // Scan modes
    localparam logic [1:0] MODE_SINGLE = 2'h0;
    localparam logic [1:0] MODE_ONCE   = 2'h1;
    localparam logic [1:0] MODE_CONT   = 2'h2;

    // Timing
    localparam int POWERUP_NS     = 200;
    localparam int CLK_PERIOD_NS  = 4;
    localparam int POWERUP_CYC    =
        (POWERUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int PRE_OFFSET     = 2;
    localparam int CONV_CYC_BASE  = 13;

    typedef enum logic [4:0] {
        ADCSQ_OFF    = 5'b00001,
        ADCSQ_WAKE   = 5'b00010,
        ADCSQ_IDLE   = 5'b00100,
        ADCSQ_DELAY  = 5'b01000,
        ADCSQ_CONV   = 5'b10000
    } adcsq_state_t;

    // Active sequence settings, latched at safe boundaries
    typedef struct packed {
        logic [1:0]  mode;
        logic [3:0]  count;
        logic [35:0] slots;
    } adcsq_seq_t;

endpackage : adcseq_pkg

// >>> src/adcseq_top.sv
// Arbitrary-channel converter sequencer with Wishbone register slave
//
// The Wishbone interface to the registers and the placing of the registers were chosen for this implementation.
`timescale 1ns/10ps

// Contract
// - First setting of power enable wakes converter from power-down.
// - Run starts converting only after the about 200ns power-up delay.
// - Clearing run stops activity; clearing enable returns to power-down.
// - Single mode converts once, on the first slot's channel only.
// - Run is set by software, external trigger or timer overflow.
// - Each result goes to common result and to its channel's register.
// - Each conversion sets end flag; interrupt raised when enabled.
// - Single mode: run reads 1 during conversion, cleared after sampling.
// - Sequence register writes mid-conversion apply after current set.
// - Scan converts slots 0 upward up to slot count; repeats allowed.
// - Each scanned slot's result stored; end flag set per channel.
// - One-cycle scan clears run after last slot, then idles.
// - Continuous scan repeats; after run cleared, current conversion finishes.
// - Continuous scan applies new slot count and selects at next scan start; mode is kept.
// - Resolution selectable up to 12 bits; eight external, one internal.
// - Triggered start waits a programmable delay; several sources.
// - Window comparator flags results meeting threshold condition.
// - Each of nine channels enabled through slot count and selects.
// - Result valid set on completion; overrun if unread; read clears.
// - Converter clock divide factor is prescaler field plus two.
module adcseq_top #(
    parameter int DATA_W = 12
) (
    input  wire logic        CLK_SYS,
    input  wire logic        RST_N,
    input  wire logic        WB_CYC_I,
    input  wire logic        WB_STB_I,
    input  wire logic        WB_WE_I,
    input  wire logic [7:0]  WB_ADR_I,
    input  wire logic [3:0]  WB_SEL_I,
    input  wire logic [31:0] WB_DAT_I,
    output logic      [31:0] WB_DAT_O,
    output logic             WB_ACK_O,
    input  wire logic [3:0]  TRIG_IN,
    input  wire logic        TIMER_OVF,
    input  wire logic [11:0] ANALOG_RESULT,
    output logic             CONVERTER_POWER_ON,
    output logic             SAMPLE_START,
    output logic      [3:0]  SAMPLE_CHANNEL,
    output logic             IRQ
);
    if (DATA_W != 12) begin : g_width_check
        $error("DATA_W must be 12");
    end

    logic [31:0] converter_config;
    logic [31:0] converter_control;
    logic [31:0] compare_limits;
    logic [31:0] slot_select_reg_lo;
    logic [31:0] slot_select_reg_hi;
    logic [31:0] any_cfg;
    logic [21:0] common_result;
    logic [DATA_W-1:0] per_channel_result [0:8];
    logic        end_of_conversion_flag;
    logic        window_flag;
    logic        woken;
    adcseq_pkg::adcsq_state_t state;
    adcseq_pkg::adcsq_seq_t   active;
    logic [3:0]  slot_idx;
    logic [7:0]  wait_cnt;
    logic [4:0]  div_cnt;
    logic [4:0]  conv_cnt;
    logic [3:0]  trig_s1, trig_s2, trig_s3;
    logic        tmr_s1, tmr_s2;
    logic        wb_ack_q;

    // Bus decode
    wire wb_req    = WB_CYC_I & WB_STB_I & ~wb_ack_q;
    wire wb_wr     = wb_req & WB_WE_I & (WB_SEL_I == 4'hF);
    wire wb_rd     = wb_req & ~WB_WE_I;
    wire wr_config = wb_wr & (WB_ADR_I == adcseq_pkg::OFS_CONFIG);
    wire wr_ctrl   = wb_wr & (WB_ADR_I == adcseq_pkg::OFS_CONTROL);
    wire wr_cmp    = wb_wr & (WB_ADR_I == adcseq_pkg::OFS_COMPARE);
    wire wr_status = wb_wr & (WB_ADR_I == adcseq_pkg::OFS_STATUS);
    wire wr_slo    = wb_wr & (WB_ADR_I == adcseq_pkg::OFS_SLOT_LO);
    wire wr_shi    = wb_wr & (WB_ADR_I == adcseq_pkg::OFS_SLOT_HI);
    wire wr_any    = wb_wr & (WB_ADR_I == adcseq_pkg::OFS_ANY_CFG);
    wire rd_result = wb_rd & (WB_ADR_I == adcseq_pkg::OFS_COMMON_RESULT);
    wire in_chan   = (WB_ADR_I >= adcseq_pkg::OFS_CHAN_FIRST) &
                     (WB_ADR_I <= adcseq_pkg::OFS_CHAN_LAST) &
                     (WB_ADR_I[1:0] == 2'h0);
    wire [7:0] chan_ofs = WB_ADR_I - adcseq_pkg::OFS_CHAN_FIRST;
    wire [3:0] chan_rd  = chan_ofs[5:2];

    wire converter_power_enable = converter_config[adcseq_pkg::CFG_POWER_BIT];
    wire conversion_run = converter_control[adcseq_pkg::CTL_RUN_BIT];
    wire end_of_conversion_irq_enable =
        converter_control[adcseq_pkg::CTL_IRQ_EN_BIT];
    wire any_channel_mode_enable = any_cfg[adcseq_pkg::ANY_MDEN_BIT];

    // Divider from prescaler field, factor is field plus two
    wire [3:0] clock_divider_setting =
        {converter_config[adcseq_pkg::CFG_PREH_LSB +: 3],
         converter_config[adcseq_pkg::CFG_PREL_BIT]};
    wire [4:0] div_top = 5'(clock_divider_setting) +
                         5'(adcseq_pkg::PRE_OFFSET - 1);
    wire adc_tick = (div_cnt == div_top);

    // Trigger sources, synchronised, edge selected
    wire [1:0] trg_sel  = converter_control[adcseq_pkg::CTL_TRGSEL_LSB +: 2];
    wire [1:0] trg_edge = converter_control[adcseq_pkg::CTL_EDGE_LSB +: 2];
    wire trg_now  = trig_s2[trg_sel];
    wire trg_prev = trig_s3[trg_sel];
    wire trg_rise = trg_now & ~trg_prev;
    wire trg_fall = ~trg_now & trg_prev;
    wire trg_hit  = converter_control[adcseq_pkg::CTL_TRG_EN_BIT] &
                    ((trg_edge == 2'h0 & (trg_rise | trg_fall)) |
                     (trg_edge == 2'h1 & trg_fall) |
                     (trg_edge == 2'h2 & trg_rise));
    wire hw_start = trg_hit | (tmr_s2 & any_channel_mode_enable);
    wire [7:0] trg_delay =
        8'(converter_control[adcseq_pkg::CTL_SHIFT_LSB +: 3]) << 2;

    // Sequence slot decode
    wire [3:0] slot_chan  = active.slots[slot_idx*4 +: 4];
    wire [3:0] last_slot  = (active.mode == adcseq_pkg::MODE_SINGLE) ?
                            4'h0 : active.count;
    wire       last_done  = (slot_idx >= last_slot) | (slot_idx == 4'h8);
    wire [3:0] res_bits   = 4'(12) -
        4'(converter_config[adcseq_pkg::CFG_RES_LSB +: 3]);
    wire [11:0] res_mask  = 12'hFFF << (4'd12 - res_bits);
    wire [11:0] sample    = ANALOG_RESULT & res_mask;
    wire [15:0] aligned   = converter_control[adcseq_pkg::CTL_ALIGN_BIT] ?
                            {sample, 4'h0} : {4'h0, sample};
    wire conv_done = (state == adcseq_pkg::ADCSQ_CONV) & adc_tick &
                     (conv_cnt == 5'(adcseq_pkg::CONV_CYC_BASE - 1));
    wire seq_latch = (active.mode == adcseq_pkg::MODE_CONT) & last_done;

    // Window comparison on the chosen channel
    wire [11:0] cmp_lo = compare_limits[11:0];
    wire [11:0] cmp_hi = compare_limits[27:16];
    wire win_hit = (cmp_hi >= cmp_lo) ?
                   (sample >= cmp_hi | sample < cmp_lo) :
                   (sample == cmp_hi | (sample > cmp_hi & sample < cmp_lo));
    wire win_ev = conv_done & converter_config[adcseq_pkg::CFG_WIN_BIT] &
        (slot_chan == converter_control[adcseq_pkg::CTL_CMPCH_LSB +: 4]) &
        win_hit;

    wire auto_clear = conv_done & last_done &
                      (active.mode != adcseq_pkg::MODE_CONT);
    wire run_set = hw_start & (state == adcseq_pkg::ADCSQ_IDLE);

    wire [31:0] status_word = {28'h0, woken, (state ==
        adcseq_pkg::ADCSQ_CONV), window_flag, end_of_conversion_flag};
    wire [31:0] rd_mux =
        (WB_ADR_I == adcseq_pkg::OFS_COMMON_RESULT) ? 32'(common_result) :
        (WB_ADR_I == adcseq_pkg::OFS_CONFIG)  ? converter_config :
        (WB_ADR_I == adcseq_pkg::OFS_CONTROL) ? converter_control :
        (WB_ADR_I == adcseq_pkg::OFS_COMPARE) ? compare_limits :
        (WB_ADR_I == adcseq_pkg::OFS_STATUS)  ? status_word :
        (WB_ADR_I == adcseq_pkg::OFS_SLOT_LO) ? slot_select_reg_lo :
        (WB_ADR_I == adcseq_pkg::OFS_SLOT_HI) ? slot_select_reg_hi :
        (WB_ADR_I == adcseq_pkg::OFS_ANY_CFG) ? any_cfg :
        in_chan ? 32'(per_channel_result[chan_rd]) : 32'h0000_0000;

    // Synchronisers for pins; first stage read only by second
    always_ff @(posedge CLK_SYS) begin
        trig_s1 <= TRIG_IN;
        trig_s2 <= trig_s1;
        trig_s3 <= trig_s2;
        tmr_s1  <= TIMER_OVF;
        tmr_s2  <= tmr_s1;
    end

    // Wishbone answer, one cycle after request
    always_ff @(posedge CLK_SYS) begin
        if (!RST_N) begin
            wb_ack_q <= 1'b0;
            WB_ACK_O <= 1'b0;
            WB_DAT_O <= adcseq_pkg::RESET_WORD;
        end else begin
            wb_ack_q <= wb_req;
            WB_ACK_O <= wb_req;
            WB_DAT_O <= wb_req ? rd_mux : 32'h0000_0000;
        end
    end

    // Software registers
    always_ff @(posedge CLK_SYS) begin
        if (!RST_N) begin
            converter_config   <= adcseq_pkg::RESET_WORD;
            compare_limits     <= adcseq_pkg::RESET_WORD;
            slot_select_reg_lo <= adcseq_pkg::RESET_WORD;
            slot_select_reg_hi <= adcseq_pkg::RESET_WORD;
            any_cfg            <= adcseq_pkg::RESET_WORD;
        end else begin
            if (wr_config) converter_config <= WB_DAT_I & 32'h0000_7FFB;
            if (wr_cmp) compare_limits <= WB_DAT_I & 32'h0FFF_0FFF;
            // Shadow copies only; live set latched at boundaries
            if (wr_slo) slot_select_reg_lo <= WB_DAT_I;
            if (wr_shi) slot_select_reg_hi <= WB_DAT_I & 32'h0000_000F;
            if (wr_any) any_cfg <= WB_DAT_I & 32'h0000_00F7;
        end
    end

    // Control register; hardware clear of run loses to software set
    always_ff @(posedge CLK_SYS) begin
        if (!RST_N) begin
            converter_control <= adcseq_pkg::RESET_WORD;
        end else if (wr_ctrl) begin
            converter_control <= WB_DAT_I & 32'h03F8_FFFE;
        end else if (!converter_power_enable) begin
            converter_control[adcseq_pkg::CTL_RUN_BIT] <= 1'b0;
        end else if (run_set) begin
            converter_control[adcseq_pkg::CTL_RUN_BIT] <= 1'b1;
        end else if (auto_clear) begin
            converter_control[adcseq_pkg::CTL_RUN_BIT] <= 1'b0;
        end
    end

    // Status flags: set wins over write-one clear
    always_ff @(posedge CLK_SYS) begin
        if (!RST_N) begin
            end_of_conversion_flag <= 1'b0;
            window_flag            <= 1'b0;
            IRQ                    <= 1'b0;
        end else begin
            end_of_conversion_flag <= conv_done | (end_of_conversion_flag &
                ~(wr_status & WB_DAT_I[adcseq_pkg::STA_EOC_BIT]));
            window_flag <= win_ev | (window_flag &
                ~(wr_status & WB_DAT_I[adcseq_pkg::STA_WIN_BIT]));
            IRQ <= (end_of_conversion_flag & end_of_conversion_irq_enable) |
                   (window_flag &
                    converter_control[adcseq_pkg::CTL_WIN_IE_BIT]);
        end
    end

    // Result storage
    always_ff @(posedge CLK_SYS) begin
        if (!RST_N) begin
            common_result <= 22'h00_0000;
            for (int i = 0; i < 9; i++) per_channel_result[i] <= 12'h000;
        end else if (conv_done) begin
            common_result <= {1'b1,
                common_result[adcseq_pkg::RES_VALID_BIT], slot_chan,
                aligned};
            if (slot_chan <= 4'h8)
                per_channel_result[slot_chan] <= sample;
        end else if (rd_result) begin
            common_result[21:20] <= 2'h0;
        end
    end

    // Converter clock divider
    always_ff @(posedge CLK_SYS) begin
        if (!RST_N || state != adcseq_pkg::ADCSQ_CONV || adc_tick)
            div_cnt <= 5'h00;
        else
            div_cnt <= div_cnt + 5'h01;
    end

    // Sequencer
    always_ff @(posedge CLK_SYS) begin
        if (!RST_N) begin
            state    <= adcseq_pkg::ADCSQ_OFF;
            woken    <= 1'b0;
            active   <= '0;
            slot_idx <= 4'h0;
            wait_cnt <= 8'h00;
            conv_cnt <= 5'h00;
        end else if (!converter_power_enable) begin
            state    <= adcseq_pkg::ADCSQ_OFF;
            woken    <= 1'b0;
        end else begin
            case (state)
                adcseq_pkg::ADCSQ_OFF: begin
                    state    <= adcseq_pkg::ADCSQ_WAKE;
                    wait_cnt <= 8'h00;
                end
                adcseq_pkg::ADCSQ_WAKE: begin
                    wait_cnt <= wait_cnt + 8'h01;
                    if (wait_cnt == 8'(adcseq_pkg::POWERUP_CYC - 1)) begin
                        state <= adcseq_pkg::ADCSQ_IDLE;
                        woken <= 1'b1;
                    end
                end
                adcseq_pkg::ADCSQ_IDLE: begin
                    // Latch sequence at start; later writes wait
                    active <= '{mode:  converter_control[
                                         adcseq_pkg::CTL_MODE_LSB +: 2],
                                count: any_cfg[adcseq_pkg::ANY_NUM_LSB +: 4],
                                slots: {slot_select_reg_hi[3:0],
                                        slot_select_reg_lo}};
                    slot_idx <= 4'h0;
                    wait_cnt <= run_set ? trg_delay :
                                conversion_run ? wait_cnt : 8'h00;
                    if (conversion_run & ~wr_ctrl)
                        state <= adcseq_pkg::ADCSQ_DELAY;
                end
                adcseq_pkg::ADCSQ_DELAY: begin
                    if (!conversion_run) begin
                        state <= adcseq_pkg::ADCSQ_IDLE;
                    end else if (wait_cnt == 8'h00) begin
                        state    <= adcseq_pkg::ADCSQ_CONV;
                        conv_cnt <= 5'h00;
                    end else begin
                        wait_cnt <= wait_cnt - 8'h01;
                    end
                end
                adcseq_pkg::ADCSQ_CONV: begin
                    if (adc_tick) conv_cnt <= conv_cnt + 5'h01;
                    if (conv_done) begin
                        conv_cnt <= 5'h00;
                        if (last_done) begin
                            slot_idx <= 4'h0;
                            if (seq_latch && conversion_run) begin
                                // New settings take hold here
                                active.count <=
                                    any_cfg[adcseq_pkg::ANY_NUM_LSB +: 4];
                                active.slots <= {slot_select_reg_hi[3:0],
                                                 slot_select_reg_lo};
                            end else begin
                                state <= adcseq_pkg::ADCSQ_IDLE;
                            end
                        end else if (conversion_run) begin
                            slot_idx <= slot_idx + 4'h1;
                        end else begin
                            state <= adcseq_pkg::ADCSQ_IDLE;
                        end
                    end
                end
                default: state <= adcseq_pkg::ADCSQ_OFF;
            endcase
        end
    end

    // Analog front-end controls
    always_ff @(posedge CLK_SYS) begin
        if (!RST_N) begin
            CONVERTER_POWER_ON <= 1'b0;
            SAMPLE_START       <= 1'b0;
            SAMPLE_CHANNEL     <= 4'h0;
        end else begin
            CONVERTER_POWER_ON <= converter_power_enable;
            SAMPLE_START   <= (state == adcseq_pkg::ADCSQ_CONV) &
                              adc_tick & (conv_cnt == 5'h00);
            SAMPLE_CHANNEL <= slot_chan;
        end
    end

    a_eoc_on_done: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
        conv_done |=> end_of_conversion_flag)
        else $error("end flag not set after conversion");

    a_eoc_sticky: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
        end_of_conversion_flag && !wr_status |=> end_of_conversion_flag)
        else $error("end flag dropped without clear");

    a_irq_follow: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
        end_of_conversion_flag && end_of_conversion_irq_enable |=> IRQ)
        else $error("interrupt missing");

    a_run_autoclr: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
        auto_clear && !wr_ctrl && !run_set |=> !conversion_run)
        else $error("run not cleared after last slot");

    a_power_off: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
        !converter_power_enable |=> state == adcseq_pkg::ADCSQ_OFF)
        else $error("not powered down");

    a_wake_delay: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
        $rose(state == adcseq_pkg::ADCSQ_WAKE) |->
        (state == adcseq_pkg::ADCSQ_WAKE || !converter_power_enable)[*8])
        else $error("power-up delay too short");

    a_valid_set: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
        conv_done |=> common_result[adcseq_pkg::RES_VALID_BIT])
        else $error("valid not set");

    a_single_one: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
        conv_done && active.mode == adcseq_pkg::MODE_SINGLE |->
        slot_idx == 4'h0)
        else $error("single mode used other slot");

    a_chan_store: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
        conv_done && slot_chan == 4'h1 |=>
        per_channel_result[1] == $past(sample))
        else $error("channel result not stored");

    a_trig_delay: assert property (@(posedge CLK_SYS)
        disable iff (!RST_N) run_set && trg_delay != 8'h00 |=> ##1
        (state != adcseq_pkg::ADCSQ_DELAY || wait_cnt != 8'h00))
        else $error("trigger delay lost");

endmodule : adcseq_top

// >>> testbench/adcseq_tb.sv
// Self-checking bench for the converter sequencer
`timescale 1ns/10ps
module testbench;
    logic        clk = 1'b0;
    logic        rst_n = 1'b0;
    logic        cyc = 1'b0;
    logic        we = 1'b0;
    logic [7:0]  adr = 8'h00;
    logic [31:0] dat = 32'h0000_0000;
    logic [31:0] rd;
    logic [31:0] dat_o;
    logic        ack;
    logic        ovf = 1'b0;
    logic [3:0]  trig = 4'h0;
    int          tmo;
    logic [11:0] ana = 12'h5A5;
    logic        pwr;
    logic        smp;
    logic        irq;
    logic [3:0]  ch;
    logic [3:0]  seen[$];
    logic [7:0]  rst_ofs[5] = '{8'h00, 8'h04, 8'h08, 8'h14, 8'h70};
    int          failures = 0;
    int          cmp_count = 0;

    // Starts come from software, the timer and trigger line 0
    adcseq_top u_dut (.CLK_SYS(clk), .RST_N(rst_n), .WB_CYC_I(cyc),
        .WB_STB_I(cyc), .WB_WE_I(we), .WB_ADR_I(adr), .WB_SEL_I(4'hF),
        .WB_DAT_I(dat), .WB_DAT_O(dat_o), .WB_ACK_O(ack),
        .TRIG_IN(trig), .TIMER_OVF(ovf), .ANALOG_RESULT(ana),
        .CONVERTER_POWER_ON(pwr), .SAMPLE_START(smp),
        .SAMPLE_CHANNEL(ch), .IRQ(irq));

    task automatic finish_test();
        $display("failures %0d comparisons %0d", failures, cmp_count);
        if (failures == 0 && cmp_count > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : finish_test

    task automatic check(input string nm, input logic [31:0] e,
                         input logic [31:0] g);
        cmp_count++;
        if (g !== e) begin
            failures++;
            $display("unexpected %s: expected %h seen %h", nm, e, g);
        end
    endtask : check

    // Entered just after a rising edge; holds request until ack
    task automatic wb(input logic w, input logic [7:0] a,
                      input logic [31:0] d);
        int n;
        n = 0;
        cyc <= 1'b1;
        we <= w;
        adr <= a;
        dat <= d;
        do begin
            @(posedge clk);
            n++;
        end while (ack !== 1'b1 && n < 20);
        rd = dat_o;
        if (n >= 20) failures++;
        cyc <= 1'b0;
        @(posedge clk);
    endtask : wb

    task automatic rdchk(input string nm, input logic [7:0] a,
                         input logic [31:0] m, input logic [31:0] e);
        wb(1'b0, a, 32'h0000_0000);
        check(nm, e, rd & m);
    endtask : rdchk

    // Polls until masked bits match; a wait that runs out fails
    task automatic wait_bit(input logic [7:0] a, input logic [31:0] m,
                            input logic [31:0] e);
        int n;
        n = 0;
        do begin
            wb(1'b0, a, 32'h0000_0000);
            n++;
        end while ((rd & m) !== e && n < 1000);
        check("poll", e, rd & m);
    endtask : wait_bit

    always @(posedge clk) begin
        if (smp === 1'b1) begin
            seen.push_back(ch);
        end
    end

    initial begin
        forever #2 clk = ~clk;
    end

    initial begin
        #200000;
        failures++;
        finish_test();
    end

    initial begin
        repeat (5) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        foreach (rst_ofs[i]) rdchk("reset", rst_ofs[i], '1, '0);
        wb(1'b1, adcseq_pkg::OFS_CONFIG, 32'h0000_0073);
        check("power pin", 32'h1, {31'h0, pwr});
        rdchk("early", adcseq_pkg::OFS_STATUS, 32'h8, 32'h0);
        wait_bit(adcseq_pkg::OFS_STATUS, 32'h8, 32'h8);
        wb(1'b1, adcseq_pkg::OFS_SLOT_LO, 32'h0000_0003);
        wb(1'b1, adcseq_pkg::OFS_ANY_CFG, 32'h0000_0001);
        seen.delete();
        wb(1'b1, adcseq_pkg::OFS_CONTROL, 32'h0000_0102);
        rdchk("run", adcseq_pkg::OFS_CONTROL, 32'h100, 32'h100);
        wait_bit(adcseq_pkg::OFS_CONTROL, 32'h100, 32'h0);
        check("single n", 32'd1, seen.size());
        check("single ch", 32'd3, seen.pop_front());
        rdchk("common", 8'h00, 32'h003F_0FFF, 32'h0023_05A5);
        rdchk("chan3", 8'h24, 32'h0000_0FFF, 32'h0000_05A5);
        check("irq", 32'h1, {31'h0, irq});
        rdchk("cleared", 8'h00, 32'h0030_0000, 32'h0);
        rdchk("eoc kept", adcseq_pkg::OFS_STATUS, 32'h1, 32'h1);
        wb(1'b1, adcseq_pkg::OFS_STATUS, 32'h0000_0001);
        @(posedge clk);
        check("irq off", 32'h0, {31'h0, irq});
        // Slots 1,5,1 with a repeat; a mid-scan write must wait
        wb(1'b1, adcseq_pkg::OFS_SLOT_LO, 32'h0000_0151);
        wb(1'b1, adcseq_pkg::OFS_ANY_CFG, 32'h0000_0021);
        ana <= 12'h3C3;
        for (int r = 0; r < 2; r++) begin
            wb(1'b1, adcseq_pkg::OFS_CONTROL, 32'h0000_0302);
            if (r == 0) wb(1'b1, adcseq_pkg::OFS_SLOT_LO, 32'h0000_0777);
            wait_bit(adcseq_pkg::OFS_CONTROL, 32'h100, 32'h0);
            check("scan n", 32'd3, seen.size());
            check("slot0", r ? 32'd7 : 32'd1, seen.pop_front());
            check("slot1", r ? 32'd7 : 32'd5, seen.pop_front());
            check("slot2", r ? 32'd7 : 32'd1, seen.pop_front());
        end
        rdchk("overrun", 8'h00, 32'h003F_0FFF, 32'h0037_03C3);
        rdchk("chan5", 8'h2C, 32'h0000_0FFF, 32'h0000_03C3);
        wb(1'b1, adcseq_pkg::OFS_CONTROL, 32'h0000_0002);
        ovf <= 1'b1;
        repeat (4) @(posedge clk);
        ovf <= 1'b0;
        wait_bit(adcseq_pkg::OFS_CONTROL, 32'h100, 32'h0);
        check("timer ch", 32'd7, seen.pop_front());
        // Continuous scan; a slot edit mid-scan lands on the next pass
        ana <= 12'h0F0;
        wb(1'b1, adcseq_pkg::OFS_SLOT_LO, 32'h0000_0042);
        wb(1'b1, adcseq_pkg::OFS_ANY_CFG, 32'h0000_0011);
        wb(1'b1, adcseq_pkg::OFS_CONTROL, 32'h0000_0502);
        wb(1'b1, adcseq_pkg::OFS_SLOT_LO, 32'h0000_0066);
        tmo = 0;
        while (seen.size() < 3 && tmo < 2000) begin
            @(posedge clk);
            tmo++;
        end
        wb(1'b1, adcseq_pkg::OFS_CONTROL, 32'h0000_0402);
        wait_bit(adcseq_pkg::OFS_STATUS, 32'h4, 32'h0);
        check("cont n", 32'd3, seen.size());
        check("cont 0", 32'd2, seen.pop_front());
        check("cont 1", 32'd4, seen.pop_front());
        check("cont 2", 32'd6, seen.pop_front());
        rdchk("chan6", 8'h30, 32'h0000_0FFF, 32'h0000_00F0);
        // Rising edge on line 0, delayed start, window hit on channel 6
        wb(1'b1, adcseq_pkg::OFS_COMPARE, 32'h0200_0100);
        wb(1'b1, adcseq_pkg::OFS_CONTROL, 32'h0218_600E);
        trig <= 4'h1;
        repeat (8) @(posedge clk);
        trig <= 4'h0;
        wait_bit(adcseq_pkg::OFS_CONTROL, 32'h100, 32'h0);
        check("trig n", 32'd1, seen.size());
        check("trig ch", 32'd6, seen.pop_front());
        rdchk("window", adcseq_pkg::OFS_STATUS, 32'h2, 32'h2);
        wb(1'b1, adcseq_pkg::OFS_CONFIG, 32'h0000_0000);
        @(posedge clk);
        check("power off", 32'h0, {31'h0, pwr});
        rdchk("down", adcseq_pkg::OFS_STATUS, 32'h8, 32'h0);
        finish_test();
    end
endmodule : testbench
